/* hdl/scsr_pkg.sv */
// Constants, register map and types of the servo command source and soft-start ramp.
// How it works
// - Accel time 0..10000 ms sets the rise time from zero to 4500 r/min.
// - Decel time 0..10000 ms, default 0, sets the fall time to zero.
// - Pulse smoothing constant, 0.1 ms steps 0..640, applies only to pulse commands.
// - Speed limit 0..4500, default 3000, clamps speed only in torque control.
// - Select 1 off, select 2 on: first internal speed, default 100 r/min.
// - Both selects on: second internal speed, default 200 r/min.
// - Select 1 on, select 2 off: third internal speed, default 300 r/min.
// - Ramping acts on internal and analog speeds, never on pulse commands.
// - Ramp slope stays constant, so duration scales with target over 4500 r/min.
// - Any external input change takes effect within 6 ms.
// - Mode 4, both selects off: follow analog speed, ramped with the accel and decel times.
// - Mode 6, both selects off: follow analog torque after input sampling only.
// - Mode 5 speed intervals: positioning-complete output shows speed coincidence.
// - Modes 7, 8, 9 turn the direction input into the mode switch input.
// - Switch off/on: mode 7 position/speed, 8 position/torque, 9 torque/speed.
// - After entering position control, pulses are dropped until positioning completes.
// - Trapezoidal ramp with independently set acceleration and deceleration slopes.
// - Lock threshold 0..4500, default 10, engages position lock in speed control.
// - Position loop gain 1..500 per second, default 40, sets holding stiffness.
// - Mode 3, both selects off: decelerate with decel time to standstill, locking once speed falls to the lock threshold.
package scsr_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CYC_PER_MS    = 1000000 / CLK_PERIOD_NS;
    localparam int INPUT_DELAY_MS = 6;
    localparam int SCAN_MS        = 1;
    localparam int SCAN_CYC       = SCAN_MS * CYC_PER_MS;

    localparam int SPEED_W = 13;
    localparam int TIME_W  = 14;
    localparam int SMOOTH_W = 10;
    localparam int GAIN_W  = 9;
    localparam int MODE_W  = 4;
    localparam int TORQ_W  = 16;
    localparam int ACC_W   = 27;

    localparam logic [SPEED_W-1:0] FULL_SCALE_RPM = 13'h1194;
    localparam logic [TIME_W-1:0]  TIME_MAX_MS    = 14'h2710;
    localparam logic [SMOOTH_W-1:0] SMOOTH_MAX    = 10'h280;
    localparam logic [GAIN_W-1:0]  GAIN_MIN       = 9'h001;
    localparam logic [GAIN_W-1:0]  GAIN_MAX       = 9'h1F4;

    localparam logic [TIME_W-1:0]   DEF_ACCEL_MS    = 14'h0000;
    localparam logic [TIME_W-1:0]   DEF_DECEL_MS    = 14'h0000;
    localparam logic [SMOOTH_W-1:0] DEF_SMOOTH      = 10'h000;
    localparam logic [SPEED_W-1:0]  DEF_SPEED_LIMIT = 13'h0BB8;
    localparam logic [SPEED_W-1:0]  DEF_INT_SPEED1  = 13'h0064;
    localparam logic [SPEED_W-1:0]  DEF_INT_SPEED2  = 13'h00C8;
    localparam logic [SPEED_W-1:0]  DEF_INT_SPEED3  = 13'h012C;
    localparam logic [SPEED_W-1:0]  DEF_LOCK_SPEED  = 13'h000A;
    localparam logic [GAIN_W-1:0]   DEF_POS_GAIN    = 9'h028;
    localparam logic [MODE_W-1:0]   DEF_MODE        = 4'h3;

    localparam logic [MODE_W-1:0] MODE_SPEED      = 4'h0;
    localparam logic [MODE_W-1:0] MODE_POSITION   = 4'h1;
    localparam logic [MODE_W-1:0] MODE_TORQUE     = 4'h2;
    localparam logic [MODE_W-1:0] MODE_INT_ONLY   = 4'h3;
    localparam logic [MODE_W-1:0] MODE_INT_SPEED  = 4'h4;
    localparam logic [MODE_W-1:0] MODE_INT_POS    = 4'h5;
    localparam logic [MODE_W-1:0] MODE_INT_TORQUE = 4'h6;
    localparam logic [MODE_W-1:0] MODE_POS_SPEED  = 4'h7;
    localparam logic [MODE_W-1:0] MODE_POS_TORQUE = 4'h8;
    localparam logic [MODE_W-1:0] MODE_SPD_TORQUE = 4'h9;
    localparam logic [MODE_W-1:0] MODE_SPD_LOCK   = 4'hA;
    localparam logic [MODE_W-1:0] MODE_POS_PROHIB = 4'hB;

    localparam logic [11:0] OFS_MODE     = 12'h000;
    localparam logic [11:0] OFS_ACCEL    = 12'h004;
    localparam logic [11:0] OFS_DECEL    = 12'h008;
    localparam logic [11:0] OFS_SMOOTH   = 12'h00C;
    localparam logic [11:0] OFS_SPD_LIM  = 12'h010;
    localparam logic [11:0] OFS_ISPD1    = 12'h014;
    localparam logic [11:0] OFS_ISPD2    = 12'h018;
    localparam logic [11:0] OFS_ISPD3    = 12'h01C;
    localparam logic [11:0] OFS_LOCK_SPD = 12'h020;
    localparam logic [11:0] OFS_POS_GAIN = 12'h024;
    localparam logic [11:0] OFS_STATUS   = 12'h028;
    localparam logic [11:0] OFS_SPD_CMD  = 12'h02C;

    localparam int ST_KIND_LSB = 0;
    localparam int ST_POS_DONE = 2;
    localparam int ST_LOCK     = 3;
    localparam int ST_GATE     = 4;
    localparam int ST_SEL1     = 8;
    localparam int ST_SEL2     = 9;
    localparam int ST_MODE_SW  = 10;

    typedef enum logic [1:0] {KIND_SPEED, KIND_POSITION, KIND_TORQUE} scsr_kind_e;
endpackage

/* hdl/scsr_core.sv */
// Command-source selection, soft-start ramp and AHB-Lite register slave of the servo drive.
`timescale 1ns/100ps
module scsr_core #(
    parameter int SCAN_CYCLES = scsr_pkg::SCAN_CYC
) (
    input  wire logic                                sys_clk,
    input  wire logic                                srst,
    input  wire logic                                ce,
    input  wire logic                                hsel,
    input  wire logic [31:0]                         haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output logic [31:0]                              hrdata,
    output logic                                     hreadyout,
    output logic                                     hresp,
    input  wire logic                                speedSelect1,
    input  wire logic                                speedSelect2,
    input  wire logic                                rotationDirectionIn,
    input  wire logic                                pulseIn,
    input  wire logic                                pulseDirIn,
    input  wire logic signed [scsr_pkg::SPEED_W:0]   analogSpeedRef,
    input  wire logic signed [scsr_pkg::TORQ_W-1:0]  analogTorqueRef,
    input  wire logic                                inPosition,
    output logic signed [scsr_pkg::SPEED_W:0]        speedCommand,
    output logic signed [scsr_pkg::TORQ_W-1:0]       torqueCommand,
    output logic [scsr_pkg::SPEED_W-1:0]             speedLimit,
    output logic [scsr_pkg::GAIN_W-1:0]              holdGain,
    output logic [scsr_pkg::SMOOTH_W-1:0]            smoothingConstant,
    output logic                                     positionLock,
    output logic                                     positioningComplete,
    output logic                                     pulseCommand,
    output logic                                     pulseDirection,
    output logic [1:0]                               activeKind
);
    import scsr_pkg::*;

    function automatic logic [SPEED_W-1:0] absSpeed(input logic signed [SPEED_W:0] v);
        absSpeed = v[SPEED_W] ? SPEED_W'(-v) : v[SPEED_W-1:0];
    endfunction

    function automatic logic [SPEED_W-1:0] clampSpeed(input logic [31:0] v);
        clampSpeed = (v > 32'(FULL_SCALE_RPM)) ? FULL_SCALE_RPM : v[SPEED_W-1:0];
    endfunction

    // Settings registers.
    logic [MODE_W-1:0]   modeReg;
    logic [TIME_W-1:0]   accelReg;
    logic [TIME_W-1:0]   decelReg;
    logic [SMOOTH_W-1:0] smoothReg;
    logic [SPEED_W-1:0]  spdLimReg;
    logic [SPEED_W-1:0]  ispd1Reg;
    logic [SPEED_W-1:0]  ispd2Reg;
    logic [SPEED_W-1:0]  ispd3Reg;
    logic [SPEED_W-1:0]  lockSpdReg;
    logic [GAIN_W-1:0]   gainReg;

    // Bus phase state.
    logic        wrPend;
    logic        rdPend;
    logic [11:0] phaseAddr;
    logic [31:0] readMux;

    // Input synchronisers: stage A feeds only stage B.
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [4:0] syncC;
    logic [4:0] stableIn;
    logic [4:0] scanIn;
    logic       pulsePrev;
    logic [31:0] scanCnt;

    // Ramp and mode state.
    logic [ACC_W-1:0] rampAcc;
    scsr_kind_e       kindReg;
    logic             pulseGate;

    wire addrAccept = hsel & htrans[1] & hready;
    wire [4:0] syncAgree = ~(syncB ^ syncC);
    wire scanTick = (scanCnt >= 32'(SCAN_CYCLES - 1));
    wire sel1 = scanIn[0];
    wire sel2 = scanIn[1];
    wire dirOrSwitch = scanIn[2];
    wire selAny = sel1 | sel2;
    wire pulseEdge = stableIn[3] & ~pulsePrev;

    // In modes 7 to 9 the direction input is the mode switch.
    wire switchModes = (modeReg == MODE_POS_SPEED) | (modeReg == MODE_POS_TORQUE)
                     | (modeReg == MODE_SPD_TORQUE);
    wire modeSwitch = switchModes & dirOrSwitch;
    wire intModes = (modeReg >= MODE_INT_ONLY) & (modeReg <= MODE_INT_TORQUE);
    wire useInternal = intModes & selAny;

    // Internal speed picked by the select pair.
    wire [SPEED_W-1:0] intMag = (sel1 & sel2) ? ispd2Reg :
                                sel2          ? ispd1Reg :
                                                ispd3Reg;
    wire signed [SPEED_W:0] intSpeed = dirOrSwitch ? -$signed({1'b0, intMag})
                                                   : $signed({1'b0, intMag});
    wire [SPEED_W-1:0] refMag = clampSpeed(32'(absSpeed(analogSpeedRef)));
    wire signed [SPEED_W:0] refSpeed = analogSpeedRef[SPEED_W] ? -$signed({1'b0, refMag})
                                                               : $signed({1'b0, refMag});

    scsr_kind_e kindNext;
    logic signed [SPEED_W:0] targetSpeed;

    always_comb begin
        kindNext = KIND_SPEED;
        targetSpeed = '0;
        case (modeReg)
            MODE_SPEED, MODE_SPD_LOCK: begin
                targetSpeed = refSpeed;
            end
            MODE_POSITION, MODE_POS_PROHIB: begin
                kindNext = KIND_POSITION;
            end
            MODE_TORQUE: begin
                kindNext = KIND_TORQUE;
            end
            MODE_INT_ONLY: begin
                targetSpeed = useInternal ? intSpeed : '0;
            end
            MODE_INT_SPEED: begin
                targetSpeed = useInternal ? intSpeed : refSpeed;
            end
            MODE_INT_POS: begin
                targetSpeed = useInternal ? intSpeed : '0;
                kindNext = useInternal ? KIND_SPEED : KIND_POSITION;
            end
            MODE_INT_TORQUE: begin
                targetSpeed = useInternal ? intSpeed : '0;
                kindNext = useInternal ? KIND_SPEED : KIND_TORQUE;
            end
            MODE_POS_SPEED: begin
                targetSpeed = modeSwitch ? refSpeed : '0;
                kindNext = modeSwitch ? KIND_SPEED : KIND_POSITION;
            end
            MODE_POS_TORQUE: begin
                kindNext = modeSwitch ? KIND_TORQUE : KIND_POSITION;
            end
            MODE_SPD_TORQUE: begin
                targetSpeed = modeSwitch ? refSpeed : '0;
                kindNext = modeSwitch ? KIND_SPEED : KIND_TORQUE;
            end
            default: begin
                targetSpeed = '0;
            end
        endcase
    end

    // Moving toward zero or across it uses the deceleration slope, away from zero
    // the acceleration slope; the two are held apart.
    wire [SPEED_W-1:0] cmdMag = absSpeed(speedCommand);
    wire [SPEED_W-1:0] tgtMag = absSpeed(targetSpeed);
    wire signFlip = (speedCommand[SPEED_W] != targetSpeed[SPEED_W]) & (tgtMag != '0);
    wire towardZero = (cmdMag != '0) & (signFlip | (tgtMag < cmdMag));
    wire [TIME_W-1:0] rampTime = towardZero ? decelReg : accelReg;
    // Full scale is added each tick against time times cycles per ms, which keeps the
    // slope fixed and so scales the duration with the speed change.
    wire [ACC_W-1:0] rampDenom = ACC_W'(rampTime) * ACC_W'(CYC_PER_MS);
    wire [ACC_W-1:0] accSum = rampAcc + ACC_W'(FULL_SCALE_RPM);
    wire rampStep = (accSum >= rampDenom);
    wire rampUp = (targetSpeed > speedCommand);
    wire signed [SPEED_W:0] stepped = rampUp ? speedCommand + 14'sh0001
                                             : speedCommand - 14'sh0001;

    wire enteringPos = (kindNext == KIND_POSITION) & (kindReg != KIND_POSITION);
    wire lockNext = (kindNext == KIND_SPEED) & (targetSpeed == '0)
                  & (cmdMag <= lockSpdReg);
    wire coincide = (speedCommand == targetSpeed);
    wire posDoneNext = (kindNext == KIND_POSITION) ? (inPosition & (cmdMag == '0))
                                                   : coincide;

    always_comb begin
        readMux = '0;
        case (phaseAddr)
            OFS_MODE:     readMux = 32'(modeReg);
            OFS_ACCEL:    readMux = 32'(accelReg);
            OFS_DECEL:    readMux = 32'(decelReg);
            OFS_SMOOTH:   readMux = 32'(smoothReg);
            OFS_SPD_LIM:  readMux = 32'(spdLimReg);
            OFS_ISPD1:    readMux = 32'(ispd1Reg);
            OFS_ISPD2:    readMux = 32'(ispd2Reg);
            OFS_ISPD3:    readMux = 32'(ispd3Reg);
            OFS_LOCK_SPD: readMux = 32'(lockSpdReg);
            OFS_POS_GAIN: readMux = 32'(gainReg);
            OFS_STATUS: begin
                readMux[ST_KIND_LSB +: 2] = kindReg;
                readMux[ST_POS_DONE] = positioningComplete;
                readMux[ST_LOCK] = positionLock;
                readMux[ST_GATE] = pulseGate;
                readMux[ST_SEL1] = sel1;
                readMux[ST_SEL2] = sel2;
                readMux[ST_MODE_SW] = dirOrSwitch;
            end
            OFS_SPD_CMD:  readMux = 32'(speedCommand);
            default:      readMux = '0;
        endcase
    end

    // Bus slave: writes take no wait state, reads one, so a read right after a write
    // to the same register already sees the new value.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            phaseAddr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            rdPend <= 1'b0;
            hreadyout <= 1'b1;
            if (rdPend) begin
                hrdata <= readMux;
            end
            if (addrAccept) begin
                phaseAddr <= {haddr[11:2], 2'b00};
                wrPend <= hwrite;
                rdPend <= ~hwrite;
                hreadyout <= hwrite;
            end else if (hready) begin
                wrPend <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            modeReg <= DEF_MODE;
            accelReg <= DEF_ACCEL_MS;
            decelReg <= DEF_DECEL_MS;
            smoothReg <= DEF_SMOOTH;
            spdLimReg <= DEF_SPEED_LIMIT;
            ispd1Reg <= DEF_INT_SPEED1;
            ispd2Reg <= DEF_INT_SPEED2;
            ispd3Reg <= DEF_INT_SPEED3;
            lockSpdReg <= DEF_LOCK_SPEED;
            gainReg <= DEF_POS_GAIN;
        end else if (ce && wrPend) begin
            case (phaseAddr)
                OFS_MODE:     modeReg <= hwdata[MODE_W-1:0];
                OFS_ACCEL:    accelReg <= (hwdata > 32'(TIME_MAX_MS)) ? TIME_MAX_MS
                                                                     : hwdata[TIME_W-1:0];
                OFS_DECEL:    decelReg <= (hwdata > 32'(TIME_MAX_MS)) ? TIME_MAX_MS
                                                                     : hwdata[TIME_W-1:0];
                OFS_SMOOTH:   smoothReg <= (hwdata > 32'(SMOOTH_MAX)) ? SMOOTH_MAX
                                                                     : hwdata[SMOOTH_W-1:0];
                OFS_SPD_LIM:  spdLimReg <= clampSpeed(hwdata);
                OFS_ISPD1:    ispd1Reg <= clampSpeed(hwdata);
                OFS_ISPD2:    ispd2Reg <= clampSpeed(hwdata);
                OFS_ISPD3:    ispd3Reg <= clampSpeed(hwdata);
                OFS_LOCK_SPD: lockSpdReg <= clampSpeed(hwdata);
                OFS_POS_GAIN: gainReg <= (hwdata > 32'(GAIN_MAX)) ? GAIN_MAX :
                                         (hwdata < 32'(GAIN_MIN)) ? GAIN_MIN :
                                         hwdata[GAIN_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Pins settle through three flops and are then scanned every millisecond, which
    // keeps the worst reaction well inside the input delay.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            stableIn <= '0;
            scanIn <= '0;
            scanCnt <= '0;
            pulsePrev <= 1'b0;
        end else if (ce) begin
            syncA <= {pulseDirIn, pulseIn, rotationDirectionIn, speedSelect2, speedSelect1};
            syncB <= syncA;
            syncC <= syncB;
            stableIn <= (syncB & syncAgree) | (stableIn & ~syncAgree);
            pulsePrev <= stableIn[3];
            scanCnt <= scanTick ? '0 : scanCnt + 32'h00000001;
            if (scanTick) begin
                scanIn <= stableIn;
            end
        end
    end

    // Ramp runs on every enabled clock, the control tick. Pulse commands never
    // pass through it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            speedCommand <= '0;
            rampAcc <= '0;
        end else if (ce) begin
            if (speedCommand == targetSpeed) begin
                rampAcc <= '0;
            end else if (rampTime == '0) begin
                speedCommand <= targetSpeed;
                rampAcc <= '0;
            end else if (rampStep) begin
                speedCommand <= stepped;
                rampAcc <= accSum - rampDenom;
            end else begin
                rampAcc <= accSum;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            kindReg <= KIND_SPEED;
            pulseGate <= 1'b0;
            positioningComplete <= 1'b0;
            positionLock <= 1'b0;
            holdGain <= '0;
            speedLimit <= FULL_SCALE_RPM;
            torqueCommand <= '0;
            smoothingConstant <= '0;
            pulseCommand <= 1'b0;
            pulseDirection <= 1'b0;
            activeKind <= '0;
        end else if (ce) begin
            kindReg <= kindNext;
            activeKind <= kindNext;
            positioningComplete <= posDoneNext;
            positionLock <= lockNext;
            holdGain <= lockNext ? gainReg : '0;
            speedLimit <= (kindNext == KIND_TORQUE) ? spdLimReg : FULL_SCALE_RPM;
            torqueCommand <= (kindNext == KIND_TORQUE) ? analogTorqueRef : '0;
            smoothingConstant <= (kindNext == KIND_POSITION) ? smoothReg : '0;
            // Entering position control closes the gate until positioning completes;
            // the host is expected to wait a further 6 ms before sending.
            if (enteringPos) begin
                pulseGate <= 1'b0;
            end else if ((kindNext == KIND_POSITION) && posDoneNext) begin
                pulseGate <= 1'b1;
            end
            pulseCommand <= pulseEdge & pulseGate & (kindReg == KIND_POSITION)
                          & (kindNext == KIND_POSITION);
            pulseDirection <= stableIn[4];
        end
    end
endmodule // scsr_core

/* testbench/scsr_core_chk.sv */
// Checker of the servo command source block.
`timescale 1ns/100ps
module scsr_core_chk (
    input wire logic               sys_clk,
    input wire logic               srst,
    input wire logic [1:0]         activeKind,
    input wire logic [12:0]        speedLimit,
    input wire logic signed [15:0] torqueCommand,
    input wire logic [8:0]         holdGain,
    input wire logic [9:0]         smoothingConstant,
    input wire logic               positionLock,
    input wire logic               pulseCommand,
    input wire logic signed [13:0] speedCommand
);
    import scsr_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence s_noTrq; (activeKind != KIND_TORQUE) [*2]; endsequence
    sequence s_noPos; (activeKind != KIND_POSITION) [*2]; endsequence
    property p_lim; s_noTrq |-> speedLimit == FULL_SCALE_RPM; endproperty
    a_lim: assert property (p_lim) else $error("limit leak");
    property p_trq; s_noTrq |-> torqueCommand == 16'h0000; endproperty
    a_trq: assert property (p_trq) else $error("torque leak");
    property p_smo; s_noPos |-> smoothingConstant == 10'h000; endproperty
    a_smo: assert property (p_smo) else $error("smoothing leak");
    property p_gain; (!positionLock) [*2] |-> holdGain == 9'h000; endproperty
    a_gain: assert property (p_gain) else $error("gain without lock");
    property p_pls;
        pulseCommand |-> activeKind == KIND_POSITION || $past(activeKind) == KIND_POSITION;
    endproperty
    a_pls: assert property (p_pls) else $error("pulse leak");
    property p_one; pulseCommand |=> !pulseCommand; endproperty
    a_one: assert property (p_one) else $error("pulse stretched");
    property p_lock;
        positionLock |-> activeKind == KIND_SPEED || $past(activeKind) == KIND_SPEED;
    endproperty
    a_lock: assert property (p_lock) else $error("lock leak");
    property p_rng; speedCommand <= 14'sh1194 && speedCommand >= -14'sh1194; endproperty
    a_rng: assert property (p_rng) else $error("speed overrange");
endmodule // scsr_core_chk
bind scsr_core scsr_core_chk u_chk (.sys_clk(sys_clk), .srst(srst), .activeKind(activeKind),
    .speedLimit(speedLimit), .torqueCommand(torqueCommand), .holdGain(holdGain),
    .smoothingConstant(smoothingConstant), .positionLock(positionLock),
    .pulseCommand(pulseCommand), .speedCommand(speedCommand));

/* testbench/scsr_host_model.sv */
// Host model sending command pulse trains.
`timescale 1ns/100ps
module scsr_host_model #(
    parameter int HOLDOFF = 24,
    parameter int NUM     = 3
) (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic rude,
    input wire logic positioningComplete,
    output logic     pulseIn,
    output logic     pulseDirIn,
    output logic     done
);
    int n;
    initial begin
        pulseIn = 1'b0;
        pulseDirIn = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (!go) begin
                done <= 1'b0;
            end else if (!done) begin
                n = 0;
                while (!rude && positioningComplete !== 1'b1 && n < 2000) begin
                    @(posedge sys_clk);
                    n++;
                end
                if (!rude) repeat (HOLDOFF) @(posedge sys_clk);
                repeat (NUM) begin
                    pulseIn <= 1'b1;
                    repeat (3) @(posedge sys_clk);
                    pulseIn <= 1'b0;
                    repeat (3) @(posedge sys_clk);
                end
                done <= 1'b1;
            end
        end
    end
endmodule // scsr_host_model

/* testbench/servo_command_source_and_ramp_test.sv */
// Bench of the servo command source block.
`timescale 1ns/100ps
module servo_command_source_and_ramp_test;
    import scsr_pkg::*;
    localparam int SETTLE = INPUT_DELAY_MS * 4;
    logic sys_clk = 0, srst = 1, hsel = 0, hwrite = 0, rdPhase = 0, go = 0, rude = 0;
    logic s1 = 0, s2 = 0, rot = 0, inPos = 0, hreadyout, pulseIn, pulseDirIn, done;
    logic positionLock, pulseCommand, positioningComplete;
    logic [1:0] htrans = 0, activeKind;
    logic [12:0] speedLimit;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, v, pulseCount = 0, expQ[$];
    logic signed [13:0] aSpd = 0, speedCommand;
    logic signed [15:0] aTrq = 0, torqueCommand;
    logic [31:0] defs[10] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'hBB8, 32'h64, 32'hC8,
        32'h12C, 32'hA, 32'h28};
    logic [1:0] sel[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    logic [1:0] kinds[6] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
    int seed = 32'h2C53, numErrors = 0, samplesChecked = 0;
    scsr_core #(.SCAN_CYCLES(4)) dut (.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .speedSelect1(s1), .speedSelect2(s2), .rotationDirectionIn(rot), .pulseIn(pulseIn),
        .pulseDirIn(pulseDirIn), .analogSpeedRef(aSpd), .analogTorqueRef(aTrq),
        .inPosition(inPos), .speedCommand(speedCommand), .torqueCommand(torqueCommand),
        .speedLimit(speedLimit), .holdGain(), .smoothingConstant(),
        .positionLock(positionLock), .positioningComplete(positioningComplete),
        .pulseCommand(pulseCommand), .pulseDirection(), .activeKind(activeKind));
    scsr_host_model host (.sys_clk(sys_clk), .go(go), .rude(rude), .pulseIn(pulseIn),
        .positioningComplete(positioningComplete), .pulseDirIn(pulseDirIn), .done(done));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bwait(input int lim);
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((hreadyout !== 1'b1 || (lim > 50 && done !== 1'b1)) && n < lim);
        if (n >= lim) begin
            numErrors++;
            summarize();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 20'h00000, a, wr};
        bwait(50);
        {hsel, htrans, hwdata, rdPhase} <= {1'b0, 2'b00, d, !wr};
        if (!wr) expQ.push_back(d);
        bwait(50);
        rdPhase <= 1'b0;
    endtask
    task automatic pins(input logic [2:0] p);
        @(posedge sys_clk);
        {s1, s2, rot} <= p;
        repeat (SETTLE) @(posedge sys_clk);
    endtask
    task automatic runHost;
        @(posedge sys_clk);
        go <= 1'b1;
        bwait(3000);
        go <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (rdPhase && hreadyout === 1'b1) check("hrdata", hrdata, expQ.pop_front());
        if (pulseCommand === 1'b1) pulseCount <= pulseCount + 1;
    end
    initial forever #50 sys_clk = ~sys_clk;
    initial begin
        repeat (100000) @(posedge sys_clk);
        numErrors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) bus(0, 12'(4 * i), defs[i]);
        bus(0, 12'h030, 32'h0);
        v = 32'($unsigned($random(seed)) % 4501);
        bus(1, OFS_SPD_LIM, v);
        for (int i = 0; i < 4; i++) begin
            pins({sel[i], 1'b0});
            bus(0, OFS_SPD_CMD, i < 3 ? defs[5 + i] : 32'h0);
        end
        check("lock", 32'(positionLock), 32'h1);
        $display("test selection done");
        for (int i = 1; i < 3; i++) bus(1, 12'(4 * i), 32'(i));
        pins(3'b010);
        check("rampUp", 32'(speedCommand < 100), 32'h1);
        repeat (300) @(posedge sys_clk);
        bus(0, OFS_SPD_CMD, 32'h64);
        pins(3'b000);
        check("rampDown", 32'(speedCommand > 0), 32'h1);
        repeat (500) @(posedge sys_clk);
        bus(0, OFS_SPD_CMD, 32'h0);
        $display("test ramp done");
        aTrq <= 16'($random(seed));
        for (int j = 0; j < 6; j++) begin
            bus(1, OFS_MODE, 32'(7 + j / 2));
            pins({2'b00, 1'(j % 2)});
            check("kind", 32'(activeKind), 32'(kinds[j]));
            if (kinds[j] == KIND_TORQUE) begin
                check("torque", 32'(torqueCommand), 32'(aTrq));
                check("limit", 32'(speedLimit), v);
            end
        end
        $display("test mode switch done");
        for (int i = 1; i < 3; i++) bus(1, 12'(4 * i), 32'h0);
        bus(1, OFS_MODE, 32'h4);
        v = 32'($unsigned($random(seed)) % 4501);
        aSpd <= 14'(v);
        pins(3'b000);
        bus(0, OFS_SPD_CMD, v);
        aSpd <= 14'h0000;
        bus(1, OFS_MODE, 32'h7);
        pins(3'b000);
        rude <= 1'b1;
        runHost();
        check("dropped", pulseCount, 32'h0);
        {inPos, rude} <= 2'b10;
        runHost();
        check("accepted", pulseCount, 32'h3);
        $display("test pulse gate done");
        summarize();
    end
endmodule // servo_command_source_and_ramp_test
